/* rtl/satc_top.sv */
// Slope converter ramp timer with capture register, flags, interrupt and Avalon-MM register slave
//
// Overview of operation
// - Ramp timer is a 16-bit up-counter stepping once per clock while running.
// - Only power-up reset clears the timer; software preloads it otherwise.
// - Ramp reset set stops the timer and keeps the capacitor discharged.
// - Clearing ramp reset starts counting from the preload and starts charging.
// - Comparator falling edge copies the timer into the 16-bit capture register.
// - A capture sets the capture flag, bit 1 of the flag register.
// - Capture interrupt needs capture enable plus global and peripheral enables.
// - At most one capture per conversion cycle, even if the comparator toggles.
// - Timer keeps counting after a capture.
// - Wrap from all ones to zero sets the overflow flag, bit 0.
// - After a wrap the timer keeps counting up from zero.
// - Overflow interrupt needs overflow enable plus global and peripheral enables.
// - Timer high byte is written first; low-first order leaves the timer stopped.
// - Timer bytes sit at 0x0e/0x0f, capture bytes at 0x15/0x16.
// - Timer and capture bytes are all readable and writable.
// - Ramp reset is bit 1 of control register zero, which resets to 0x02.
`timescale 1ns/10ps
module satc_top
    import satc_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    input  wire logic [9:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        comparator_in,
    output logic             irq,
    output logic             ramp_discharge,
    output logic      [3:0]  channel_select,
    output logic             mux_out_enable,
    output logic             zero_enable,
    output logic      [3:0]  current_select,
    output logic      [3:0]  port_config,
    output logic             reference_power_down,
    output logic             converter_power_down
);

    logic [15:0] ramp_timer_reg;
    logic [15:0] ramp_capture_reg;
    logic [7:0]  irq_ctrl_reg;
    logic [7:0]  flags_reg;
    logic [7:0]  flags_next;
    logic [7:0]  periph_en_reg;
    logic [7:0]  conv_ctl0_reg;
    logic [7:0]  conv_ctl1_reg;
    logic [7:0]  sleep_ctl_reg;
    logic        wait_reg;
    logic [31:0] rdata_reg;
    logic [7:0]  rdata_next;
    logic        irq_reg;
    logic        high_pending_reg;
    logic        order_block_reg;
    logic        armed_reg;
    logic        comp_sync;
    logic        comp_prev_reg;
    logic [7:0]  bus_index;
    logic [7:0]  wbyte;
    logic        wr_ok;
    logic        wr_tmr_low;
    logic        wr_tmr_high;
    logic        wr_cap_low;
    logic        wr_cap_high;
    logic        running;
    logic        comp_fall;
    logic        capture_evt;
    logic        overflow_evt;
    logic        irq_next;

    assign bus_index   = avs_address[BUS_ADDR_W-1:2];
    assign wbyte       = avs_writedata[DATA_W-1:0];
    assign wr_ok       = avs_write && !wait_reg && avs_byteenable[0];
    assign wr_tmr_low  = wr_ok && (bus_index == IDX_TMR_LOW);
    assign wr_tmr_high = wr_ok && (bus_index == IDX_TMR_HIGH);
    assign wr_cap_low  = wr_ok && (bus_index == IDX_CAP_LOW);
    assign wr_cap_high = wr_ok && (bus_index == IDX_CAP_HIGH);

    // Timer runs only out of ramp reset and after a correct byte order
    assign running      = !conv_ctl0_reg[BIT_RAMP_RST] && !order_block_reg;
    assign overflow_evt = running && !wr_tmr_low && !wr_tmr_high
                          && (ramp_timer_reg == TIMER_ALL_ONES);
    assign comp_fall    = comp_prev_reg && !comp_sync;
    assign capture_evt  = comp_fall && armed_reg && !conv_ctl0_reg[BIT_RAMP_RST];

    // Register outputs
    assign avs_readdata         = rdata_reg;
    assign avs_waitrequest      = wait_reg;
    assign irq                  = irq_reg;
    assign ramp_discharge       = conv_ctl0_reg[BIT_RAMP_RST];
    assign channel_select       = conv_ctl0_reg[FLD_HI_LSB +: 4];
    assign mux_out_enable       = conv_ctl0_reg[BIT_MUX_OE];
    assign zero_enable          = conv_ctl0_reg[BIT_ZERO_EN];
    assign current_select       = conv_ctl1_reg[FLD_HI_LSB +: 4];
    assign port_config          = conv_ctl1_reg[FLD_LO_LSB +: 4];
    assign reference_power_down = sleep_ctl_reg[BIT_REF_PD];
    assign converter_power_down = sleep_ctl_reg[BIT_CONV_PD];

    satc_sync u_comp_sync (
        .ref_clk  (ref_clk),
        .nrst     (nrst),
        .async_in (comparator_in),
        .sync_out (comp_sync)
    );

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            comp_prev_reg <= 1'b0;
        end else begin
            comp_prev_reg <= comp_sync;
        end
    end

    // Bus slave: one wait cycle; read data is latched as waitrequest drops, and a write takes effect one edge later
    always_comb begin
        rdata_next = 8'h00;
        case (bus_index)
            IDX_IRQ_CTRL:   rdata_next = irq_ctrl_reg;
            IDX_PERIPH_FLG: rdata_next = flags_reg;
            IDX_TMR_LOW:    rdata_next = ramp_timer_reg[7:0];
            IDX_TMR_HIGH:   rdata_next = ramp_timer_reg[15:8];
            IDX_CAP_LOW:    rdata_next = ramp_capture_reg[7:0];
            IDX_CAP_HIGH:   rdata_next = ramp_capture_reg[15:8];
            IDX_CONV_CTL0:  rdata_next = conv_ctl0_reg;
            IDX_PERIPH_EN:  rdata_next = periph_en_reg;
            IDX_SLEEP_CTL:  rdata_next = sleep_ctl_reg;
            IDX_CONV_CTL1:  rdata_next = conv_ctl1_reg;
            default:        rdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            wait_reg  <= 1'b1;
            rdata_reg <= 32'h00000000;
        end else begin
            if ((avs_read || avs_write) && wait_reg) begin
                wait_reg  <= 1'b0;
                rdata_reg <= {24'h000000, rdata_next};
            end else begin
                wait_reg  <= 1'b1;
            end
        end
    end

    // Control registers
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            irq_ctrl_reg  <= RST_IRQ_CTRL;
            periph_en_reg <= RST_PERIPH_EN;
            conv_ctl0_reg <= RST_CONV_CTL0;
            conv_ctl1_reg <= RST_CONV_CTL1;
            sleep_ctl_reg <= RST_SLEEP_CTL;
        end else if (wr_ok) begin
            case (bus_index)
                IDX_IRQ_CTRL:  irq_ctrl_reg  <= wbyte & MASK_IRQ_CTRL;
                IDX_PERIPH_EN: periph_en_reg <= wbyte & MASK_FLAGS;
                IDX_CONV_CTL0: conv_ctl0_reg <= wbyte & MASK_CONV_CTL0;
                IDX_CONV_CTL1: conv_ctl1_reg <= wbyte;
                IDX_SLEEP_CTL: sleep_ctl_reg <= wbyte & MASK_SLEEP_CTL;
                default:       irq_ctrl_reg  <= irq_ctrl_reg;
            endcase
        end
    end

    // Flags: hardware set wins over a software clear in the same cycle
    always_comb begin
        flags_next = flags_reg;
        if (wr_ok && (bus_index == IDX_PERIPH_FLG)) begin
            flags_next = wbyte & MASK_FLAGS;
        end
        if (capture_evt) begin
            flags_next[BIT_CAPTURE] = 1'b1;
        end
        if (overflow_evt) begin
            flags_next[BIT_OVERFLOW] = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            flags_reg <= RST_FLAGS;
        end else begin
            flags_reg <= flags_next;
        end
    end

    // Byte order guard: a low write with no high write before it stops the timer
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            high_pending_reg <= 1'b0;
            order_block_reg  <= 1'b0;
        end else if (wr_tmr_high) begin
            high_pending_reg <= 1'b1;
        end else if (wr_tmr_low) begin
            high_pending_reg <= 1'b0;
            order_block_reg  <= !high_pending_reg;
        end
    end

    // Ramp timer
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ramp_timer_reg <= RST_TIMER;
        end else if (wr_tmr_high) begin
            ramp_timer_reg[15:8] <= wbyte;
        end else if (wr_tmr_low) begin
            ramp_timer_reg[7:0] <= wbyte;
        end else if (running) begin
            ramp_timer_reg <= ramp_timer_reg + TIMER_STEP;
        end
    end

    // One capture per conversion: re-armed while ramp reset is held
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            armed_reg <= 1'b0;
        end else if (conv_ctl0_reg[BIT_RAMP_RST]) begin
            armed_reg <= 1'b1;
        end else if (capture_evt) begin
            armed_reg <= 1'b0;
        end
    end

    // Capture register: a capture wins over a software byte write
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ramp_capture_reg <= RST_CAPTURE;
        end else if (capture_evt) begin
            ramp_capture_reg <= ramp_timer_reg;
        end else if (wr_cap_low) begin
            ramp_capture_reg[7:0] <= wbyte;
        end else if (wr_cap_high) begin
            ramp_capture_reg[15:8] <= wbyte;
        end
    end

    // Interrupt output
    assign irq_next = irq_ctrl_reg[BIT_GLOBAL_EN] && irq_ctrl_reg[BIT_PERIPH_EN]
                      && ((flags_reg[BIT_CAPTURE] && periph_en_reg[BIT_CAPTURE])
                      || (flags_reg[BIT_OVERFLOW] && periph_en_reg[BIT_OVERFLOW]));

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= irq_next;
        end
    end

    // Checks
    property p_count;
        @(posedge ref_clk) disable iff (!nrst)
        (running && !wr_tmr_low && !wr_tmr_high) |=> (ramp_timer_reg == $past(ramp_timer_reg) + TIMER_STEP);
    endproperty

    AST_TIMER_COUNTS: assert property (p_count)
        else $error("ramp timer did not step while running");

    AST_TIMER_HELD: assert property (@(posedge ref_clk) disable iff (!nrst)
        (conv_ctl0_reg[BIT_RAMP_RST] && !wr_tmr_low && !wr_tmr_high) |=> $stable(ramp_timer_reg))
        else $error("ramp timer moved during ramp reset");

    AST_CAPTURE_LOAD: assert property (@(posedge ref_clk) disable iff (!nrst)
        capture_evt |=> (ramp_capture_reg == $past(ramp_timer_reg)) && flags_reg[BIT_CAPTURE])
        else $error("capture did not copy the timer or set the flag");

    AST_CAPTURE_ONCE: assert property (@(posedge ref_clk) disable iff (!nrst)
        (capture_evt ##1 (!conv_ctl0_reg[BIT_RAMP_RST])[*2]) |-> !capture_evt)
        else $error("second capture in one conversion");

    AST_COUNT_AFTER_CAPTURE: assert property (@(posedge ref_clk) disable iff (!nrst)
        (capture_evt && running && !wr_tmr_low && !wr_tmr_high) |=> (ramp_timer_reg != $past(ramp_timer_reg)))
        else $error("timer stopped at capture");

    AST_OVERFLOW_WRAP: assert property (@(posedge ref_clk) disable iff (!nrst)
        overflow_evt |=> (ramp_timer_reg == RST_TIMER) && flags_reg[BIT_OVERFLOW] ##1
        (!running || ramp_timer_reg == TIMER_STEP))
        else $error("overflow wrap or flag wrong");

    AST_IRQ_GATING: assert property (@(posedge ref_clk) disable iff (!nrst)
        ##1 (irq == ($past(irq_ctrl_reg[BIT_GLOBAL_EN]) && $past(irq_ctrl_reg[BIT_PERIPH_EN])
        && (($past(flags_reg[BIT_CAPTURE]) && $past(periph_en_reg[BIT_CAPTURE]))
        || ($past(flags_reg[BIT_OVERFLOW]) && $past(periph_en_reg[BIT_OVERFLOW]))))))
        else $error("interrupt output does not match enables and flags");

    AST_OVF_IRQ: assert property (@(posedge ref_clk) disable iff (!nrst)
        (flags_reg[BIT_OVERFLOW] && periph_en_reg[BIT_OVERFLOW] && irq_ctrl_reg[BIT_GLOBAL_EN]
        && irq_ctrl_reg[BIT_PERIPH_EN]) |=> irq)
        else $error("overflow interrupt missing");

    AST_ORDER_BLOCK: assert property (@(posedge ref_clk) disable iff (!nrst)
        (wr_tmr_low && !high_pending_reg) |=> !running ##1 (ramp_timer_reg == $past(ramp_timer_reg) || wr_ok))
        else $error("timer runs after low-first write");

    AST_CAPTURE_KEEP: assert property (@(posedge ref_clk) disable iff (!nrst)
        (!capture_evt && !wr_cap_low && !wr_cap_high) |=> $stable(ramp_capture_reg))
        else $error("capture register changed without cause");

    AST_BUS_ANSWER: assert property (@(posedge ref_clk) disable iff (!nrst)
        ((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not after one wait cycle");

    COV_CAPTURE: cover property (@(posedge ref_clk) disable iff (!nrst) capture_evt);
    COV_OVERFLOW: cover property (@(posedge ref_clk) disable iff (!nrst) overflow_evt);
    COV_IRQ: cover property (@(posedge ref_clk) disable iff (!nrst) $rose(irq));
    COV_ORDER_BLOCK: cover property (@(posedge ref_clk) disable iff (!nrst) $rose(order_block_reg));

endmodule

/* rtl/satc_pkg.sv */
// Package with the register map, field positions and reset values of the slope converter timer block
package satc_pkg;

    localparam int unsigned DATA_W         = 8;
    localparam int unsigned TIMER_W        = 16;
    localparam int unsigned BUS_ADDR_W     = 10;
    localparam int unsigned INDEX_W        = 8;

    // Register indices; the byte address on the bus is four times the index
    localparam logic [7:0]  IDX_IRQ_CTRL   = 8'h0b;
    localparam logic [7:0]  IDX_PERIPH_FLG = 8'h0c;
    localparam logic [7:0]  IDX_TMR_LOW    = 8'h0e;
    localparam logic [7:0]  IDX_TMR_HIGH   = 8'h0f;
    localparam logic [7:0]  IDX_CAP_LOW    = 8'h15;
    localparam logic [7:0]  IDX_CAP_HIGH   = 8'h16;
    localparam logic [7:0]  IDX_CONV_CTL0  = 8'h1f;
    localparam logic [7:0]  IDX_PERIPH_EN  = 8'h8c;
    localparam logic [7:0]  IDX_SLEEP_CTL  = 8'h8f;
    localparam logic [7:0]  IDX_CONV_CTL1  = 8'h9f;

    // Field positions
    localparam int unsigned BIT_GLOBAL_EN  = 7;
    localparam int unsigned BIT_PERIPH_EN  = 6;
    localparam int unsigned BIT_CAPTURE    = 1;
    localparam int unsigned BIT_OVERFLOW   = 0;
    localparam int unsigned BIT_RAMP_RST   = 1;
    localparam int unsigned BIT_MUX_OE     = 2;
    localparam int unsigned BIT_ZERO_EN    = 0;
    localparam int unsigned BIT_UNUSED_C0  = 3;
    localparam int unsigned BIT_REF_PD     = 5;
    localparam int unsigned BIT_CONV_PD    = 0;
    localparam int unsigned FLD_HI_LSB     = 4;
    localparam int unsigned FLD_LO_LSB     = 0;

    // Writable masks
    localparam logic [7:0]  MASK_IRQ_CTRL  = 8'hc0;
    localparam logic [7:0]  MASK_FLAGS     = 8'h03;
    localparam logic [7:0]  MASK_CONV_CTL0 = 8'hf7;
    localparam logic [7:0]  MASK_SLEEP_CTL = 8'h21;

    // Reset values and timer constants
    localparam logic [7:0]  RST_IRQ_CTRL   = 8'h00;
    localparam logic [7:0]  RST_FLAGS      = 8'h00;
    localparam logic [7:0]  RST_PERIPH_EN  = 8'h00;
    localparam logic [7:0]  RST_CONV_CTL0  = 8'h02;
    localparam logic [7:0]  RST_CONV_CTL1  = 8'h00;
    localparam logic [7:0]  RST_SLEEP_CTL  = 8'h21;
    localparam logic [15:0] RST_TIMER      = 16'h0000;
    localparam logic [15:0] RST_CAPTURE    = 16'h0000;
    localparam logic [15:0] TIMER_ALL_ONES = 16'hffff;
    localparam logic [15:0] TIMER_STEP     = 16'h0001;

    // Least discharge time software must give the ramp capacitor
    localparam int unsigned DISCHARGE_MIN_US = 200;
    localparam int unsigned CLK_MHZ          = 250;
    localparam int unsigned DISCHARGE_CYCLES = DISCHARGE_MIN_US * CLK_MHZ;

endpackage

/* rtl/satc_sync.sv */
// Two-stage synchroniser for one asynchronous input level
`timescale 1ns/10ps
module satc_sync (
    input  wire logic ref_clk,
    input  wire logic nrst,
    input  wire logic async_in,
    output logic      sync_out
);
    logic meta_reg;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            meta_reg <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule

/* verif/satc_ramp_model.sv */
// Behavioural ramp and comparator on the far side of the slope converter timer
`timescale 1ns/10ps
module satc_ramp_model (
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    input  wire logic        ramp_discharge,
    input  wire logic [15:0] trip_count,
    input  wire logic        bounce,
    output logic             comparator_out
);
    logic [15:0] ramp_reg;

    // Ramp level in clock steps; saturates at all ones so only bounce or a discharge can raise the comparator again after it trips
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ramp_reg <= 16'h0000;
        end else if (ramp_discharge) begin
            ramp_reg <= 16'h0000;
        end else if (ramp_reg != 16'hffff) begin
            ramp_reg <= ramp_reg + 16'h0001;
        end
    end

    // Output high while the ramp is below the input; bounce forces a second fall
    assign comparator_out = (ramp_reg < trip_count) | bounce;
endmodule

/* verif/slope_adc_timer_capture_test.sv */
// Self-checking bench for the slope converter timer, capture and register slave
`timescale 1ns/10ps
module slope_adc_timer_capture_test;
    import satc_pkg::*;

    typedef struct packed {
        logic       wr;
        logic [7:0] idx;
        logic [7:0] data;
        logic [7:0] exp;
        logic       irq_exp;
    } satc_row_t;

    logic        ref_clk;
    logic        nrst;
    logic [9:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        comparator_in;
    logic        irq;
    logic        ramp_discharge;
    logic [3:0]  channel_select;
    logic        mux_out_enable;
    logic        zero_enable;
    logic [3:0]  current_select;
    logic [3:0]  port_config;
    logic        reference_power_down;
    logic        converter_power_down;
    logic [15:0] trip_count;
    logic        bounce;
    int          bad_count;
    int          n_checks;
    satc_row_t   rows [27];
    logic [7:0]  q;
    logic [7:0]  q2;
    logic [15:0] cap;

    satc_top i_dut (
        .ref_clk              (ref_clk),
        .nrst                 (nrst),
        .avs_address          (avs_address),
        .avs_read             (avs_read),
        .avs_write            (avs_write),
        .avs_writedata        (avs_writedata),
        .avs_byteenable       (4'hf),
        .avs_readdata         (avs_readdata),
        .avs_waitrequest      (avs_waitrequest),
        .comparator_in        (comparator_in),
        .irq                  (irq),
        .ramp_discharge       (ramp_discharge),
        .channel_select       (channel_select),
        .mux_out_enable       (mux_out_enable),
        .zero_enable          (zero_enable),
        .current_select       (current_select),
        .port_config          (port_config),
        .reference_power_down (reference_power_down),
        .converter_power_down (converter_power_down)
    );

    satc_ramp_model i_ramp (
        .ref_clk        (ref_clk),
        .nrst           (nrst),
        .ramp_discharge (ramp_discharge),
        .trip_count     (trip_count),
        .bounce         (bounce),
        .comparator_out (comparator_in)
    );

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Holds the request until waitrequest is sampled low, then releases and idles one cycle
    task automatic av_xfer(input logic wr, input logic [7:0] idx, input logic [7:0] d, output logic [7:0] r);
        int k;
        avs_address   <= {idx, 2'b00};
        avs_writedata <= {24'h000000, d};
        avs_write     <= wr;
        avs_read      <= ~wr;
        for (k = 0; k < 20; k++) begin
            @(posedge ref_clk);
            if (avs_waitrequest === 1'b0) break;
        end
        r = avs_readdata[7:0];
        if (k == 20) begin
            bad_count++;
            tally_and_finish();
        end
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic av_wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] dummy;
        av_xfer(1'b1, idx, d, dummy);
    endtask

    task automatic av_rd(input logic [7:0] idx, output logic [7:0] r);
        av_xfer(1'b0, idx, 8'h00, r);
    endtask

    task automatic wait_irq();
        int k;
        for (k = 0; k < 300 && irq !== 1'b1; k++) @(posedge ref_clk);
        chk("irq_raised", {31'h0, irq}, 32'h1);
        if (irq !== 1'b1) tally_and_finish();
    endtask

    initial begin
        repeat (80000) @(posedge ref_clk);
        bad_count++;
        tally_and_finish();
    end

    initial begin
        bad_count = 0;
        n_checks = 0;
        nrst = 1'b0;
        avs_address = 10'h000;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h00000000;
        trip_count = 16'hffff;
        bounce = 1'b0;
        rows = '{
            '{1'b0, IDX_TMR_LOW, 8'h00, 8'h00, 1'b0}, '{1'b0, IDX_TMR_HIGH, 8'h00, 8'h00, 1'b0},
            '{1'b0, IDX_CAP_LOW, 8'h00, 8'h00, 1'b0}, '{1'b0, IDX_CAP_HIGH, 8'h00, 8'h00, 1'b0},
            '{1'b0, IDX_CONV_CTL0, 8'h00, 8'h02, 1'b0}, '{1'b0, IDX_SLEEP_CTL, 8'h00, 8'h21, 1'b0},
            '{1'b0, IDX_IRQ_CTRL, 8'h00, 8'h00, 1'b0}, '{1'b0, IDX_PERIPH_FLG, 8'h00, 8'h00, 1'b0},
            '{1'b0, IDX_PERIPH_EN, 8'h00, 8'h00, 1'b0}, '{1'b0, IDX_CONV_CTL1, 8'h00, 8'h00, 1'b0},
            '{1'b1, IDX_CAP_LOW, 8'ha5, 8'ha5, 1'b0}, '{1'b1, IDX_CAP_HIGH, 8'h5a, 8'h5a, 1'b0},
            '{1'b1, IDX_TMR_HIGH, 8'h12, 8'h12, 1'b0}, '{1'b1, IDX_TMR_LOW, 8'h34, 8'h34, 1'b0},
            '{1'b1, IDX_CONV_CTL1, 8'h3c, 8'h3c, 1'b0}, '{1'b1, IDX_CONV_CTL0, 8'hfe, 8'hf6, 1'b0},
            '{1'b1, IDX_SLEEP_CTL, 8'h00, 8'h00, 1'b0}, '{1'b1, 8'h40, 8'hff, 8'h00, 1'b0},
            '{1'b1, IDX_PERIPH_FLG, 8'h01, 8'h01, 1'b0}, '{1'b1, IDX_PERIPH_EN, 8'h01, 8'h01, 1'b0},
            '{1'b1, IDX_IRQ_CTRL, 8'h80, 8'h80, 1'b0}, '{1'b1, IDX_IRQ_CTRL, 8'h40, 8'h40, 1'b0},
            '{1'b1, IDX_IRQ_CTRL, 8'hc0, 8'hc0, 1'b1}, '{1'b1, IDX_PERIPH_EN, 8'h02, 8'h02, 1'b0},
            '{1'b1, IDX_PERIPH_FLG, 8'h02, 8'h02, 1'b1}, '{1'b1, IDX_IRQ_CTRL, 8'h00, 8'h00, 1'b0},
            '{1'b1, IDX_PERIPH_FLG, 8'h00, 8'h00, 1'b0}};
        repeat (6) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        chk("waitrequest_idle", {31'h0, avs_waitrequest}, 32'h1);
        chk("discharge_at_reset", {31'h0, ramp_discharge}, 32'h1);
        chk("power_down_at_reset", {30'h0, reference_power_down, converter_power_down}, 32'h3);
        foreach (rows[i]) begin
            if (rows[i].wr) av_wr(rows[i].idx, rows[i].data);
            av_rd(rows[i].idx, q);
            chk("register_readback", {24'h0, q}, {24'h0, rows[i].exp});
            chk("irq_gating", {31'h0, irq}, {31'h0, rows[i].irq_exp});
        end
        chk("control_outputs", {23'h0, channel_select, mux_out_enable, zero_enable, ramp_discharge},
            {23'h0, 4'hf, 1'b1, 1'b0, 1'b1});
        chk("control1_outputs", {24'h0, current_select, port_config}, 32'h0000003c);
        chk("power_down_cleared", {30'h0, reference_power_down, converter_power_down}, 32'h0);
        // Capture near the top of the count, then the wrap that follows it
        trip_count <= 16'd20;
        av_wr(IDX_IRQ_CTRL, 8'hc0);
        av_wr(IDX_PERIPH_EN, 8'h02);
        av_wr(IDX_TMR_HIGH, 8'hff);
        av_wr(IDX_TMR_LOW, 8'hc0);
        repeat (DISCHARGE_CYCLES) @(posedge ref_clk);
        av_wr(IDX_CONV_CTL0, 8'h00);
        chk("discharge_released", {31'h0, ramp_discharge}, 32'h0);
        wait_irq();
        av_rd(IDX_PERIPH_FLG, q);
        chk("capture_flag", {24'h0, q}, 32'h02);
        av_rd(IDX_CAP_LOW, q);
        av_rd(IDX_CAP_HIGH, q2);
        cap = {q2, q};
        chk("capture_window", {31'h0, cap >= 16'hffd4 && cap <= 16'hffd8}, 32'h1);
        bounce <= 1'b1;
        repeat (3) @(posedge ref_clk);
        bounce <= 1'b0;
        for (int k = 0; k < 40 && q[0] !== 1'b1; k++) av_rd(IDX_PERIPH_FLG, q);
        chk("overflow_after_capture", {24'h0, q}, 32'h03);
        if (q[0] !== 1'b1) tally_and_finish();
        av_rd(IDX_CAP_LOW, q);
        av_rd(IDX_CAP_HIGH, q2);
        chk("capture_held", {16'h0, q2, q}, {16'h0, cap});
        av_wr(IDX_CONV_CTL0, 8'h02);
        chk("discharge_set", {31'h0, ramp_discharge}, 32'h1);
        // Timer is read only once the ramp is stopped again
        av_rd(IDX_TMR_HIGH, q);
        chk("timer_after_wrap", {24'h0, q}, 32'h00);
        av_rd(IDX_TMR_LOW, q);
        av_rd(IDX_TMR_LOW, q2);
        chk("timer_stopped", {24'h0, q2}, {24'h0, q});
        av_wr(IDX_PERIPH_FLG, 8'h00);
        av_rd(IDX_PERIPH_FLG, q);
        chk("irq_cleared", {31'h0, irq}, 32'h0);
        // Low byte first leaves the timer stopped even with ramp reset cleared
        av_wr(IDX_TMR_LOW, 8'h50);
        av_wr(IDX_CONV_CTL0, 8'h00);
        av_rd(IDX_TMR_LOW, q);
        av_rd(IDX_TMR_LOW, q2);
        chk("reverse_order_stopped", {16'h0, q, q2}, 32'h00005050);
        av_wr(IDX_CONV_CTL0, 8'h02);
        tally_and_finish();
    end
endmodule
